/* File: logic/wss_map.svh */
/*
 * Register offsets, field positions, reset values and timing counts of the
 * waveform steering and shutdown block.
 * Assumes a 32-bit APB slave with byte addresses on aligned words.
 */
`ifndef WSS_MAP_SVH
`define WSS_MAP_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define WSS_OFF_STEER_CTRL   12'h000
`define WSS_OFF_WAVE_CTRL1   12'h004
`define WSS_OFF_SHDN_CTRL    12'h008
`define WSS_OFF_SHDN_SRC     12'h00c
`define WSS_OFF_IRQ_STATUS   12'h010
`define WSS_OFF_IRQ_ENABLE   12'h014
`define WSS_OFF_IRQ_CLEAR    12'h018
`define WSS_OFF_PIN_STATUS   12'h01c

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define WSS_STEER_LSB        0
`define WSS_MODE_LSB         8
`define WSS_ENABLE_BIT       12
`define WSS_HFOSC_SEL_BIT    13
`define WSS_POL_LSB          0
`define WSS_SHDN_BIT         7
`define WSS_RESTART_BIT      6
`define WSS_OVR_LSB          0
`define WSS_IRQ_SHDN_BIT     0
`define WSS_IRQ_RESUME_BIT   1

// ----------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------
`define WSS_RST_STEER_CTRL   32'h0000_0000
`define WSS_RST_WAVE_CTRL1   32'h0000_0000
`define WSS_RST_SHDN_CTRL    32'h0000_0000
`define WSS_RST_SHDN_SRC     32'h0000_0000
`define WSS_MODE_ASYNC       3'h0
`define WSS_MODE_SYNC        3'h1
`define WSS_SYNC_STAGES      2

`endif

/* File: logic/wss_pkg.sv */
/*
 * Types shared by the waveform steering and shutdown block.
 * Assumes wss_map.svh supplies all numeric constants.
 */
package wss_pkg;
    // Shutdown state of the output stage
    typedef enum logic [0:0] {
        WSS_RUN,
        WSS_SHUT
    } wss_state_type;
    typedef logic [3:0] wss_pins_type;
endpackage

/* File: logic/wss_sync.sv */
/*
 * Two-stage synchroniser for one level crossing into pclk.
 * Assumes the input is asynchronous to pclk; only stage two is read.
 */
`timescale 1ns/1ps
module wss_sync (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    input  wire logic async_in,
    input  wire logic reset_val,
    output logic      sync_out
);
    logic meta_reg;
    logic hold_reg;

    // ------------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------------
    // Stages keep the input relative to its idle level, so reset stays a
    // constant zero while the output still leaves reset at the tie-off level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_reg <= 1'b0;
            hold_reg <= 1'b0;
        end else if (clk_en) begin
            meta_reg <= async_in ^ reset_val;
            hold_reg <= meta_reg;
        end
    end

    // Tie-off is constant, so this is only a buffer or an inverter
    assign sync_out = hold_reg ^ reset_val;
endmodule

/* File: logic/wss_pin.sv */
/*
 * One output lane: steering, polarity and shutdown override of one pin.
 * Assumes steer enable, shutdown state and override level are on pclk.
 */
`timescale 1ns/1ps
module wss_pin (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    input  wire logic data_in,
    input  wire logic steer_en,
    input  wire logic polarity,
    input  wire logic fixed_level,
    input  wire logic shut,
    input  wire logic ovr_level,
    output logic      pin_out
);
    logic steered;
    logic pin_next;

    // ------------------------------------------------------------------
    // Lane selection
    // ------------------------------------------------------------------
    // Polarity only touches steered data; shutdown only touches steered lanes
    assign steered  = data_in ^ polarity;
    assign pin_next = !steer_en ? fixed_level :
                      shut      ? ovr_level   :
                                  steered;

    // Registered so the pin is glitch free
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= 1'b0;
        end else if (clk_en) begin
            pin_out <= pin_next;
        end
    end
endmodule

/* File: logic/wss_top.sv */
/*
 * Waveform steering and auto-shutdown output stage with APB registers.
 * Assumes pclk is the block's own selected clock, that the data input,
 * the shutdown pin and comparator outputs are asynchronous, and that the
 * timer pulse already runs on pclk.
 */
`timescale 1ns/1ps
`include "wss_map.svh"

// Operation
// - In a steering mode any mix of the four pins may carry the input signal at once.
// - A pin with steer enable clear holds its fixed level.
// - A pin with steer enable set follows the input data signal.
// - Polarity inverts only steered pins.
// - Shutdown overrides only steered pins.
// - In asynchronous mode new steer enables act as soon as the write completes.
// - In synchronous mode new steer enables act at the next input rising edge.
// - Entering shutdown replaces levels at once; leaving is automatic or by software.
// - Setting the software shutdown bit forces shutdown.
// - Without auto-restart shutdown lasts while the software bit stays set.
// - With auto-restart the bit clears itself and output resumes on the next rising edge.
// - An active selected external source forces override levels at once.
// - All four sources are active low and each is selected in a source register.
// - Sources are level sensed and shutdown cannot clear while one stays active.
// - The block runs on its own clock and keeps running in sleep.
// - In sleep the fast internal oscillator is held on when enabled, active and selected.
module wss_top (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  clk_en,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  data_in,
    input  wire logic                  comparator_one_synced_out,
    input  wire logic                  comparator_two_synced_out,
    input  wire logic                  timer_postscaled_pulse,
    input  wire logic                  shutdown_input_pin,
    input  wire logic                  input_source_active,
    output wss_pkg::wss_pins_type      waveform_output_pins,
    output logic                       high_freq_internal_osc_keep,
    output logic                       irq
);
    import wss_pkg::*;

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    logic [3:0]    steer_enable_n_reg;   // software view
    logic [3:0]    steer_active_reg;     // applied to the pins
    logic [2:0]    mode_reg;
    logic          enable_reg;
    logic          hfosc_sel_reg;
    logic [3:0]    output_polarity_n_reg;
    logic [3:0]    fixed_level_reg;
    logic [3:0]    ovr_level_reg;
    logic          sw_shdn_reg;
    logic          restart_reg;
    logic [3:0]    src_sel_reg;
    logic [1:0]    irq_status_reg;
    logic [1:0]    irq_enable_reg;
    logic          data_d_reg;
    wss_state_type state_reg;
    wss_state_type state_next;

    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic data_s;
    logic cmp1_s;
    logic cmp2_s;
    logic pin_s;

    wss_sync u_sync_data (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .async_in  (data_in),
        .reset_val (1'b0),
        .sync_out  (data_s)
    );
    wss_sync u_sync_cmp1 (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .async_in  (comparator_one_synced_out),
        .reset_val (1'b1),
        .sync_out  (cmp1_s)
    );
    wss_sync u_sync_cmp2 (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .async_in  (comparator_two_synced_out),
        .reset_val (1'b1),
        .sync_out  (cmp2_s)
    );
    wss_sync u_sync_pin (
        .pclk      (pclk),
        .presetn   (presetn),
        .clk_en    (clk_en),
        .async_in  (shutdown_input_pin),
        .reset_val (1'b1),
        .sync_out  (pin_s)
    );

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Every access takes one wait state; registered pready completes it in the second access cycle
    logic access;
    logic wr_en;
    logic rd_en;
    logic hit_steer;
    logic hit_wave;
    logic hit_shdn;
    logic hit_src;
    logic hit_ists;
    logic hit_ien;
    logic hit_iclr;
    logic hit_pins;
    logic mapped;

    assign access    = psel && penable && !pready && clk_en;
    assign wr_en     = access && pwrite;
    assign rd_en     = access && !pwrite;
    assign hit_steer = (paddr == `WSS_OFF_STEER_CTRL);
    assign hit_wave  = (paddr == `WSS_OFF_WAVE_CTRL1);
    assign hit_shdn  = (paddr == `WSS_OFF_SHDN_CTRL);
    assign hit_src   = (paddr == `WSS_OFF_SHDN_SRC);
    assign hit_ists  = (paddr == `WSS_OFF_IRQ_STATUS);
    assign hit_ien   = (paddr == `WSS_OFF_IRQ_ENABLE);
    assign hit_iclr  = (paddr == `WSS_OFF_IRQ_CLEAR);
    assign hit_pins  = (paddr == `WSS_OFF_PIN_STATUS);
    assign mapped    = hit_steer | hit_wave | hit_shdn | hit_src |
                       hit_ists | hit_ien | hit_iclr | hit_pins;

    // Read mux; clear register reads zero
    logic [31:0] rd_mux;
    assign rd_mux =
        hit_steer ? {18'h0_0000, hfosc_sel_reg, enable_reg, 1'b0, mode_reg,
                     4'h0, steer_enable_n_reg} :
        hit_wave  ? {28'h000_0000, output_polarity_n_reg} :
        hit_shdn  ? {16'h0000, sw_shdn_reg, restart_reg, 6'h00,
                     ovr_level_reg, fixed_level_reg} :
        hit_src   ? {28'h000_0000, src_sel_reg} :
        hit_ists  ? {30'h0000_0000, irq_status_reg} :
        hit_ien   ? {30'h0000_0000, irq_enable_reg} :
        hit_pins  ? {27'h000_0000, (state_reg == WSS_SHUT), waveform_output_pins} :
                    32'h0000_0000;

    // ------------------------------------------------------------------
    // Shutdown sensing
    // ------------------------------------------------------------------
    // Level sensed, active low, each gated by its select bit
    logic ext_shdn;
    logic data_rise;
    logic entering;
    logic leaving;
    assign ext_shdn  = (src_sel_reg[0] && !cmp1_s) ||
                       (src_sel_reg[1] && !cmp2_s) ||
                       (src_sel_reg[2] && !timer_postscaled_pulse) ||
                       (src_sel_reg[3] && !pin_s);
    assign data_rise = data_s && !data_d_reg;

    // Exit only on an input rising edge with every selected source gone and the software bit clear or auto-restart set
    always_comb begin
        case (state_reg)
            WSS_RUN: begin
                state_next = (sw_shdn_reg || ext_shdn) ? WSS_SHUT : WSS_RUN;
            end
            WSS_SHUT: begin
                if (!ext_shdn && data_rise && (restart_reg || !sw_shdn_reg)) begin
                    state_next = WSS_RUN;
                end else begin
                    state_next = WSS_SHUT;
                end
            end
            default: begin
                state_next = WSS_SHUT;
            end
        endcase
    end
    assign entering = (state_reg == WSS_RUN) && (state_next == WSS_SHUT);
    assign leaving  = (state_reg == WSS_SHUT) && (state_next == WSS_RUN);

    // Override is applied the same cycle shutdown is detected
    logic shut_now;
    assign shut_now = (state_reg == WSS_SHUT) || sw_shdn_reg || ext_shdn;

    // ------------------------------------------------------------------
    // APB outputs
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (clk_en) begin
            pready  <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped;
            prdata  <= rd_en ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steer_enable_n_reg    <= 4'h0;
            mode_reg              <= 3'h0;
            enable_reg            <= 1'b0;
            hfosc_sel_reg         <= 1'b0;
            output_polarity_n_reg <= 4'h0;
            fixed_level_reg       <= 4'h0;
            ovr_level_reg         <= 4'h0;
            restart_reg           <= 1'b0;
            src_sel_reg           <= 4'h0;
            irq_enable_reg        <= 2'h0;
        end else if (clk_en && wr_en) begin
            if (hit_steer) begin
                steer_enable_n_reg <= pwdata[`WSS_STEER_LSB +: 4];
                mode_reg           <= pwdata[`WSS_MODE_LSB +: 3];
                enable_reg         <= pwdata[`WSS_ENABLE_BIT];
                hfosc_sel_reg      <= pwdata[`WSS_HFOSC_SEL_BIT];
            end
            if (hit_wave) begin
                output_polarity_n_reg <= pwdata[`WSS_POL_LSB +: 4];
            end
            if (hit_shdn) begin
                fixed_level_reg <= pwdata[`WSS_OVR_LSB +: 4];
                ovr_level_reg   <= pwdata[`WSS_OVR_LSB + 4 +: 4];
                restart_reg     <= pwdata[`WSS_RESTART_BIT + 8];
            end
            if (hit_src) begin
                src_sel_reg <= pwdata[3:0];
            end
            if (hit_ien) begin
                irq_enable_reg <= pwdata[1:0];
            end
        end
    end

    // Software bit: write sets/clears, auto-restart clears it on resume
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_shdn_reg <= 1'b0;
        end else if (clk_en) begin
            if (wr_en && hit_shdn) begin
                sw_shdn_reg <= pwdata[`WSS_SHDN_BIT + 8];
            end else if (leaving && restart_reg) begin
                sw_shdn_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Steering application and state
    // ------------------------------------------------------------------
    // Sync mode defers a new steer set to the next data rising edge; lanes
    // use the applied set in that same cycle, so no sliver of old data escapes
    logic [3:0] steer_apply;
    assign steer_apply = (mode_reg != `WSS_MODE_SYNC) ? steer_enable_n_reg :
                         data_rise ? steer_enable_n_reg :
                                     steer_active_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            steer_active_reg <= 4'h0;
            data_d_reg       <= 1'b0;
            state_reg        <= WSS_RUN;
        end else if (clk_en) begin
            data_d_reg       <= data_s;
            state_reg        <= state_next;
            steer_active_reg <= steer_apply;
        end
    end

    // ------------------------------------------------------------------
    // Output lanes
    // ------------------------------------------------------------------
    // One lane per pin; any mix may carry the data at once
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
            wss_pin u_pin (
                .pclk        (pclk),
                .presetn     (presetn),
                .clk_en      (clk_en),
                .data_in     (data_s),
                .steer_en    (steer_apply[gi]),
                .polarity    (output_polarity_n_reg[gi]),
                .fixed_level (fixed_level_reg[gi]),
                .shut        (shut_now),
                .ovr_level   (ovr_level_reg[gi]),
                .pin_out     (waveform_output_pins[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------------
    // Sleep clock request and interrupts
    // ------------------------------------------------------------------
    // Held on regardless of system clock choice; pclk keeps running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            high_freq_internal_osc_keep <= 1'b0;
        end else if (clk_en) begin
            high_freq_internal_osc_keep <= enable_reg && input_source_active &&
                                           hfosc_sel_reg;
        end
    end

    // Sticky events: set wins over a same-cycle clear
    logic [1:0] irq_events;
    logic [1:0] irq_clr;
    assign irq_events = {leaving, entering};
    assign irq_clr    = (wr_en && hit_iclr) ? pwdata[1:0] : 2'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_status_reg <= 2'h0;
            irq            <= 1'b0;
        end else if (clk_en) begin
            irq_status_reg <= (irq_status_reg & ~irq_clr) | irq_events;
            irq            <= |(((irq_status_reg & ~irq_clr) | irq_events) & irq_enable_reg);
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    chk_fixed_level: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && !steer_apply[0] |=> waveform_output_pins[0] == $past(fixed_level_reg[0]))
        else $error("unsteered pin not at fixed level");
    chk_steered_data: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && steer_apply[1] && !shut_now
        |=> waveform_output_pins[1] == ($past(data_s) ^ $past(output_polarity_n_reg[1])))
        else $error("steered pin not following data");
    chk_shut_override: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && steer_apply[2] && shut_now
        |=> waveform_output_pins[2] == $past(ovr_level_reg[2]))
        else $error("shutdown override missing");
    chk_sw_shutdown: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && sw_shdn_reg && state_reg == WSS_RUN |=> state_reg == WSS_SHUT)
        else $error("software shutdown ignored");
    chk_hold_no_restart: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == WSS_SHUT && sw_shdn_reg && !restart_reg |=> state_reg == WSS_SHUT)
        else $error("shutdown left while bit set");
    chk_level_holds: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == WSS_SHUT && ext_shdn |=> state_reg == WSS_SHUT)
        else $error("shutdown cleared with source active");
    chk_async_steer: assert property (@(posedge pclk) disable iff (!presetn)
        clk_en && mode_reg == `WSS_MODE_ASYNC |=> steer_active_reg == $past(steer_enable_n_reg))
        else $error("async steer not applied");
    chk_sync_steer: assert property (@(posedge pclk) disable iff (!presetn)
        mode_reg == `WSS_MODE_SYNC && !data_rise |=> $stable(steer_active_reg))
        else $error("sync steer applied off edge");
endmodule

/* File: dv/wss_power_stage.sv */
/*
 * Model of the power switching stage fed by the four output pins.
 * Assumes the pins are registered on pclk and the stage only listens.
 */
`timescale 1ns/1ps
module wss_power_stage (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [3:0] gate_drive,
    output logic      [7:0] switch_count
);
    logic prev_reg;
    // Counts turn-on events of the first leg, as a load would see them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev_reg     <= 1'b0;
            switch_count <= 8'h00;
        end else begin
            prev_reg <= gate_drive[0];
            if (gate_drive[0] && !prev_reg) begin
                switch_count <= switch_count + 8'h01;
            end
        end
    end
endmodule

/* File: dv/waveform_steering_shutdown_tb_top.sv */
/*
 * Self-checking bench of the steering and shutdown output stage.
 * Assumes wss_top with its APB slave and the power stage model beside it.
 */
`timescale 1ns/1ps
module waveform_steering_shutdown_tb_top;
    import wss_pkg::*;
    logic                pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic                data_in = 0, src_act = 0, pready, pslverr, keep, irq;
    logic         [3:0]  src_n = 4'hf;
    logic         [11:0] paddr = 12'h000;
    logic         [31:0] pwdata = 32'h0, prdata;
    logic         [7:0]  sw_cnt;
    wss_pins_type        pins;
    int                  err_count = 0, num_checks = 0, cycles = 0;

    wss_top i_dut (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .data_in(data_in),
        .comparator_one_synced_out(src_n[0]), .comparator_two_synced_out(src_n[1]),
        .timer_postscaled_pulse(src_n[2]), .shutdown_input_pin(src_n[3]),
        .input_source_active(src_act), .waveform_output_pins(pins),
        .high_freq_internal_osc_keep(keep), .irq(irq));
    wss_power_stage i_load (.pclk(pclk), .presetn(presetn), .gate_drive(pins),
        .switch_count(sw_cnt));

    // ------------------------------------------------------------------
    // Clock, reset and hang guard
    // ------------------------------------------------------------------
    initial begin
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 4000) begin
            err_count++;
            report_and_stop();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        if (err_count == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_pins(input wss_pins_type exp);
        num_checks++;
        if (pins !== exp) begin
            err_count++;
            $display("BAD %0t pins %b expected %b", $time, pins, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // Request stays put until pready is seen; the guard ends any hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, d, r, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk_word(r, exp);
        chk_word(32'(e), 32'(err));
    endtask
    task automatic pulse_data();
        data_in <= 1'b0;
        cyc(4);
        data_in <= 1'b1;
        cyc(6);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_regs();
        for (int i = 0; i < 4; i++) rd(12'(4 * i), 32'h0, 1'b0);
        rd(12'h040, 32'h0, 1'b1);
    endtask
    task automatic t_steer();
        wr(12'h000, 32'h1005);
        wr(12'h004, 32'h4);
        wr(12'h008, 32'h1a);
        data_in <= 1'b1;
        cyc(4);
        chk_pins(4'b1011);
        data_in <= 1'b0;
        cyc(4);
        chk_pins(4'b1110);
        wr(12'h000, 32'h100f);
        cyc(2);
        chk_pins(4'b0100);
    endtask
    task automatic t_sync();
        wr(12'h004, 32'h0);
        wr(12'h000, 32'h1100);
        cyc(3);
        chk_pins(4'b0000);
        data_in <= 1'b1;
        cyc(4);
        chk_pins(4'b1010);
        wr(12'h000, 32'h1005);
    endtask
    task automatic t_soft();
        wr(12'h014, 32'h1);
        wr(12'h008, 32'h801a);
        cyc(2);
        chk_pins(4'b1011);
        chk_word(32'(irq), 32'h1);
        rd(12'h01c, 32'h1b, 1'b0);
        pulse_data();
        chk_pins(4'b1011);
        wr(12'h014, 32'h0);
        cyc(2);
        chk_word(32'(irq), 32'h0);
        wr(12'h018, 32'h1);
        wr(12'h014, 32'h1);
        cyc(2);
        chk_word(32'(irq), 32'h0);
        wr(12'h008, 32'h1a);
        pulse_data();
        chk_pins(4'b1111);
    endtask
    task automatic t_auto();
        wr(12'h008, 32'hc01a);
        cyc(2);
        chk_pins(4'b1011);
        pulse_data();
        chk_pins(4'b1111);
        rd(12'h008, 32'h401a, 1'b0);
    endtask
    task automatic t_ext();
        for (int i = 0; i < 4; i++) begin
            wr(12'h00c, 32'h1 << i);
            src_n[i] <= 1'b0;
            cyc(5);
            chk_pins(4'b1011);
            pulse_data();
            chk_pins(4'b1011);
            src_n[i] <= 1'b1;
            pulse_data();
            chk_pins(4'b1111);
        end
    endtask
    task automatic t_sleep();
        logic [7:0] c;
        wr(12'h000, 32'h3005);
        src_act <= 1'b1;
        cyc(3);
        chk_word(32'(keep), 32'h1);
        src_act <= 1'b0;
        cyc(3);
        chk_word(32'(keep), 32'h0);
        c = sw_cnt;
        pulse_data();
        c = sw_cnt - c;
        chk_word(32'(c), 32'h1);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        cyc(2);
        presetn <= 1'b1;
        t_regs();
        t_steer();
        t_sync();
        t_soft();
        t_auto();
        t_ext();
        t_sleep();
        report_and_stop();
    end
endmodule
